// *** src/oao_top.sv ***
// Purpose: Thermal watchdog alarm with two-wire serial register slave
// Assumes: Conversion result arrives with a one-cycle done pulse
// Notes: Alarm and data lines are open-drain, enables active low
//
// Operation
// R1: Interrupt mode first trips above high limit, held until a read.
// R2: After a cleared trip, next trip is below low limit; alternating.
// R3: Interrupt mode alarm cleared by register read or shutdown entry.
// R4: Comparator mode sets above high limit, clears below low limit.
// R5: Comparator mode alarm unaffected by reads and shutdown.
// R6: Alarm changes only after programmed consecutive tripping conversions.
// R7: Fault select 00/01/10/11 needs 1/2/4/6 faults; resets to 00.
// R8: Polarity bit 1 gives active-high alarm, 0 active-low; resets 0.
// R9: Mode bit 1 selects interrupt, 0 comparator; resets 0.
// R10: Shutdown bit 1 enters shutdown, 0 returns to normal.
// R11: Shutdown stops conversions; serial reads and writes still served.
// R12: Power-up: normal, comparator, 80 and 75 limits, pointer zero.
// R13: Temperature reading valid only after first conversion finishes.
// R14: Controller must keep high limit above low limit.
// R15: Slave address is 1001 plus three address-select pins.
// R16: Address 0Ch may draw a false alert; controller avoids it.
// R17: Controller drives serial clock; device is slave only.
// R18: Compare top nine temperature bits with nine-bit signed limits.
// R19: Compare at end of each conversion, after updating temperature.
// R20: Fault counter clears on non-trip, and on alarm set or clear.
// R21: Any completed read transaction clears interrupt-mode alarm.

module oao_top
    import oao_pkg::*;
#(
    parameter logic [7:0] ID_VALUE = 8'h5a // Arbitrary value
) (
    input wire logic mclk_in,
    input wire logic srst_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n_out,
    input wire logic addr_select_bit2_in,
    input wire logic addr_select_bit1_in,
    input wire logic addr_select_bit0_in,
    input wire logic [oao_pkg::TEMP_W-1:0] temp_result_in,
    input wire logic conv_done_in,
    output logic conv_run_out,
    output logic [1:0] conv_rate_out,
    output logic temp_valid_out,
    output logic overtemp_alarm_out,
    output logic overtemp_alarm_oe_n_out
);
    import oao_pkg::*;

    // ************************************************************
    // Input synchronisation and bus events
    // ************************************************************
    logic [4:0] sync_q;
    logic scl_s, sda_s, scl_d_ff, sda_d_ff;
    logic scl_rise, scl_fall, bus_start, bus_stop;
    logic [2:0] pins;

    oao_sync #(.W(5), .INIT(SYNC_RESET)) u_sync (
        .clk_in(mclk_in),
        .rst_in(srst_in),
        .d_in({scl_in, sda_in, addr_select_bit2_in, addr_select_bit1_in,
               addr_select_bit0_in}),
        .q_out(sync_q)
    );

    assign scl_s = sync_q[4];
    assign sda_s = sync_q[3];
    assign pins = sync_q[2:0];

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end else begin
            scl_d_ff <= scl_s;
            sda_d_ff <= sda_s;
        end
    end

    assign scl_rise = scl_s & ~scl_d_ff;
    assign scl_fall = ~scl_s & scl_d_ff;
    assign bus_start = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
    assign bus_stop = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

    // ************************************************************
    // Serial slave
    // ************************************************************
    oao_state_t state_ff;
    logic [7:0] shreg_ff, txreg_ff, rd_byte;
    logic [2:0] bitcnt_ff;
    logic byte_done_ff, rw_ff, rd_seen_ff, rbyte_ff;
    logic [1:0] wbyte_ff;
    logic wr_fire, read_done, addr_hit;
    logic [7:0] ptr_ff, conf_ff;
    logic [LIMIT_W-1:0] tos_ff, thyst_ff;
    logic [TEMP_W-1:0] temp_ff;

    assign addr_hit = (shreg_ff[7:1] == {ADDR_FIXED, pins}); // see R15, R16
    assign wr_fire = (state_ff == ST_WR) & scl_fall & byte_done_ff;
    // Read ends at stop or repeated start after any byte went out
    assign read_done = (bus_start | bus_stop) & rd_seen_ff; // see R21

    always_comb begin
        rd_byte = 8'h00;
        unique case (ptr_ff)
            PTR_TEMP: rd_byte = rbyte_ff ? {temp_ff[4:0], 3'h0}
                                         : temp_ff[12:5];
            PTR_CONF: rd_byte = conf_ff;
            PTR_THYST: rd_byte = rbyte_ff ? {thyst_ff[0], 7'h00}
                                          : thyst_ff[8:1];
            PTR_TOS: rd_byte = rbyte_ff ? {tos_ff[0], 7'h00} : tos_ff[8:1];
            PTR_ID: rd_byte = ID_VALUE;
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            state_ff <= ST_IDLE;
            shreg_ff <= 8'h00;
            txreg_ff <= 8'h00;
            bitcnt_ff <= 3'h0;
            byte_done_ff <= 1'b0;
            rw_ff <= 1'b0;
            wbyte_ff <= 2'h0;
            rbyte_ff <= 1'b0;
            rd_seen_ff <= 1'b0;
            sda_oe_n_out <= 1'b1;
        end else if (bus_start | bus_stop) begin
            state_ff <= bus_start ? ST_ADDR : ST_IDLE;
            bitcnt_ff <= 3'h0;
            byte_done_ff <= 1'b0;
            // First byte of any read must be the high byte
            rbyte_ff <= 1'b0;
            rd_seen_ff <= 1'b0;
            sda_oe_n_out <= 1'b1;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                end
                ST_ADDR, ST_WR: begin
                    if (scl_rise) begin
                        shreg_ff <= {shreg_ff[6:0], sda_s};
                        bitcnt_ff <= 3'(bitcnt_ff + 3'h1);
                        byte_done_ff <= (bitcnt_ff == 3'h7);
                    end else if (scl_fall && byte_done_ff) begin
                        byte_done_ff <= 1'b0;
                        if (state_ff == ST_WR) begin
                            sda_oe_n_out <= 1'b0;
                            state_ff <= ST_ACK_W;
                            if (wbyte_ff != 2'h3) begin
                                wbyte_ff <= 2'(wbyte_ff + 2'h1);
                            end
                        end else if (addr_hit) begin
                            sda_oe_n_out <= 1'b0;
                            rw_ff <= shreg_ff[0];
                            state_ff <= ST_ACK_A;
                        end else begin
                            state_ff <= ST_IDLE;
                        end
                    end
                end
                ST_ACK_A: begin
                    if (scl_fall) begin
                        bitcnt_ff <= 3'h0;
                        wbyte_ff <= 2'h0;
                        rbyte_ff <= 1'b0;
                        if (rw_ff) begin
                            txreg_ff <= rd_byte;
                            sda_oe_n_out <= rd_byte[7];
                            state_ff <= ST_RD;
                        end else begin
                            sda_oe_n_out <= 1'b1;
                            state_ff <= ST_WR;
                        end
                    end
                end
                ST_ACK_W: begin
                    if (scl_fall) begin
                        sda_oe_n_out <= 1'b1;
                        state_ff <= ST_WR;
                    end
                end
                ST_RD: begin
                    if (scl_rise) begin
                        bitcnt_ff <= 3'(bitcnt_ff + 3'h1);
                        byte_done_ff <= (bitcnt_ff == 3'h7);
                    end else if (scl_fall) begin
                        if (byte_done_ff) begin
                            byte_done_ff <= 1'b0;
                            sda_oe_n_out <= 1'b1;
                            rbyte_ff <= ~rbyte_ff;
                            state_ff <= ST_ACK_R;
                        end else begin
                            txreg_ff <= {txreg_ff[6:0], 1'b0};
                            sda_oe_n_out <= txreg_ff[6];
                        end
                    end
                end
                ST_ACK_R: begin
                    if (scl_rise) begin
                        rd_seen_ff <= 1'b1;
                        byte_done_ff <= ~sda_s;
                        if (sda_s) begin
                            state_ff <= ST_IDLE;
                        end
                    end else if (scl_fall && byte_done_ff) begin
                        byte_done_ff <= 1'b0;
                        bitcnt_ff <= 3'h0;
                        txreg_ff <= rd_byte;
                        sda_oe_n_out <= rd_byte[7];
                        state_ff <= ST_RD;
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // Shutdown does not gate this path, so writes work in shutdown
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            ptr_ff <= PTR_RESET; // see R12
            conf_ff <= CONF_RESET; // see R7, R8, R9, R12
            tos_ff <= TOS_RESET;
            thyst_ff <= THYST_RESET;
        end else if (wr_fire) begin // see R11
            if (wbyte_ff == 2'h0) begin
                ptr_ff <= shreg_ff;
            end else if (ptr_ff == PTR_CONF && wbyte_ff == 2'h1) begin
                conf_ff <= shreg_ff; // see R10
            end else if (ptr_ff == PTR_TOS) begin
                if (wbyte_ff == 2'h1) tos_ff[8:1] <= shreg_ff;
                else tos_ff[0] <= shreg_ff[7];
            end else if (ptr_ff == PTR_THYST) begin
                if (wbyte_ff == 2'h1) thyst_ff[8:1] <= shreg_ff;
                else thyst_ff[0] <= shreg_ff[7];
            end
        end
    end

    // ************************************************************
    // Conversion control and result capture
    // ************************************************************
    logic shdn, int_mode, conv_eval;

    assign shdn = conf_ff[CONF_SHDN];
    assign int_mode = conf_ff[CONF_MODE];
    assign conv_eval = conv_done_in & ~shdn; // see R19

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            temp_ff <= '0;
            temp_valid_out <= 1'b0;
            conv_run_out <= 1'b1;
            conv_rate_out <= 2'h0;
        end else begin
            conv_run_out <= ~shdn; // see R10, R11
            conv_rate_out <= conf_ff[CONF_RATE_LO +: 2];
            if (conv_eval) begin
                temp_ff <= temp_result_in;
                temp_valid_out <= 1'b1; // see R13
            end
        end
    end

    // ************************************************************
    // Alarm decision
    // ************************************************************
    logic signed [LIMIT_W-1:0] temp9;
    logic over, under, trip, fire, int_clear, shdn_d_ff;
    logic alarm_ff, expect_low_ff;
    logic [2:0] fault_cnt_ff, needed;

    // Limit order is the controller's duty; no guard here, see R14
    assign temp9 = $signed(temp_result_in[TEMP_W-1 -: LIMIT_W]); // see R18
    assign over = temp9 > $signed(tos_ff);
    assign under = temp9 < $signed(thyst_ff);
    assign needed = oao_fault_needed(conf_ff[CONF_FQ_LO +: 2]); // see R7
    assign trip = int_mode ? (~alarm_ff & (expect_low_ff ? under : over))
                           : (alarm_ff ? under : over); // see R1, R2, R4
    assign fire = conv_eval & trip & (fault_cnt_ff + 3'h1 >= needed);
    assign int_clear = int_mode & alarm_ff
                     & (read_done | (shdn & ~shdn_d_ff)); // see R3

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            alarm_ff <= 1'b0;
            expect_low_ff <= 1'b0;
            shdn_d_ff <= 1'b0;
        end else begin
            shdn_d_ff <= shdn;
            // Set wins over clear, though modes keep them apart
            if (fire) begin
                alarm_ff <= int_mode ? 1'b1 : ~alarm_ff; // see R4, R6
            end else if (int_clear) begin
                alarm_ff <= 1'b0; // see R3, R5
                expect_low_ff <= ~expect_low_ff; // see R2
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            fault_cnt_ff <= 3'h0;
        end else if (int_clear || (conv_eval && (!trip || fire))) begin
            fault_cnt_ff <= 3'h0; // see R20
        end else if (conv_eval) begin
            fault_cnt_ff <= 3'(fault_cnt_ff + 3'h1); // see R6
        end
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            overtemp_alarm_oe_n_out <= 1'b1;
            overtemp_alarm_out <= 1'b0;
            sda_out <= 1'b0;
        end else begin
            // Pin pulled low unless alarm_ff equals the polarity bit
            overtemp_alarm_oe_n_out <= (alarm_ff == conf_ff[CONF_POL]); // see R8
            overtemp_alarm_out <= 1'b0;
            sda_out <= 1'b0;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (srst_in);

    chk_pin_polarity: assert property ( // see R8
        ##1 overtemp_alarm_oe_n_out ==
            ($past(alarm_ff) == $past(conf_ff[CONF_POL])))
        else $error("alarm pin level disagrees with polarity");
    chk_comp_hold: assert property ( // see R5
        (!int_mode && !fire) |=> $stable(alarm_ff))
        else $error("comparator alarm changed without a fault");
    chk_int_clear: assert property ( // see R3, R21
        (int_mode && alarm_ff && read_done) |=> !alarm_ff)
        else $error("interrupt alarm not cleared by read");
    chk_fault_count: assert property ( // see R6
        fire |-> (fault_cnt_ff == 3'(needed - 3'h1)))
        else $error("alarm fired before fault queue filled");
    chk_queue_block: assert property ( // see R6, R7
        (conv_eval && trip && (fault_cnt_ff + 3'h1 < needed))
        |=> $stable(alarm_ff) && fault_cnt_ff == $past(fault_cnt_ff) + 3'h1)
        else $error("short fault run changed alarm");
    chk_shdn_stop: assert property ( // see R11
        shdn [*2] |-> !conv_run_out)
        else $error("conversions run in shutdown");
    chk_addr_ack: assert property ( // see R15
        (state_ff == ST_ADDR && scl_fall && byte_done_ff && addr_hit
         && !bus_start && !bus_stop) |=> !sda_oe_n_out)
        else $error("own address not acknowledged");
    chk_alternate: assert property ( // see R2
        (int_clear && !fire) |=> expect_low_ff != $past(expect_low_ff))
        else $error("interrupt trip limit did not alternate");
    chk_comp_hyst: assert property ( // see R4
        (!int_mode && conv_eval && !alarm_ff && !over) |=> !alarm_ff)
        else $error("comparator alarm set without high limit crossing");
    chk_cnt_clear: assert property ( // see R20
        (conv_eval && !trip) |=> fault_cnt_ff == 3'h0)
        else $error("fault counter kept after clean conversion");
endmodule : oao_top

// *** shared/oao_pkg.sv ***
// Purpose: Shared constants and types for the overtemp alarm block
// Assumes: 25 MHz system clock, serial link sampled as plain inputs
// Notes: Limits are 9-bit two's complement in half-degree steps

package oao_pkg;

    // ************************************************************
    // Slave address and register pointers
    // ************************************************************
    localparam logic [3:0] ADDR_FIXED = 4'h9;
    localparam logic [7:0] PTR_TEMP = 8'h00;
    localparam logic [7:0] PTR_CONF = 8'h01;
    localparam logic [7:0] PTR_THYST = 8'h02;
    localparam logic [7:0] PTR_TOS = 8'h03;
    localparam logic [7:0] PTR_ID = 8'h05;
    localparam logic [7:0] PTR_RESET = 8'h00;

    // ************************************************************
    // Configuration layout and power-up values
    // ************************************************************
    localparam int CONF_SHDN = 0;
    localparam int CONF_MODE = 1;
    localparam int CONF_POL = 2;
    localparam int CONF_FQ_LO = 3;
    localparam int CONF_RATE_LO = 5;
    localparam logic [7:0] CONF_RESET = 8'h00;
    localparam int TEMP_W = 13;
    localparam int LIMIT_W = 9;
    localparam logic [LIMIT_W-1:0] TOS_RESET = 9'h0a0;
    localparam logic [LIMIT_W-1:0] THYST_RESET = 9'h096;
    localparam logic [4:0] SYNC_RESET = 5'h18;

    // ************************************************************
    // Serial slave states
    // ************************************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ACK_A = 3'b011,
        ST_WR = 3'b010,
        ST_ACK_W = 3'b110,
        ST_RD = 3'b111,
        ST_ACK_R = 3'b101
    } oao_state_t;

    function automatic logic [2:0] oao_fault_needed(input logic [1:0] sel);
        logic [2:0] n;
        unique case (sel)
            2'h0: n = 3'h1;
            2'h1: n = 3'h2;
            2'h2: n = 3'h4;
            2'h3: n = 3'h6;
        endcase
        return n;
    endfunction : oao_fault_needed

endpackage : oao_pkg

// *** src/oao_sync.sv ***
// Purpose: Two-flop synchroniser for a group of asynchronous inputs
// Assumes: Bits are independent levels, no bus coherency needed
// Notes: Reset value chosen per bit so idle lines look idle

module oao_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta_ff;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            meta_ff <= INIT;
            q_out <= INIT;
        end else begin
            meta_ff <= d_in;
            q_out <= meta_ff;
        end
    end
endmodule : oao_sync

// *** verif/oao_i2c_ctrl.sv ***
// Purpose: Behavioural two-wire bus controller driving the alarm block
// Assumes: Pull-up on the data line, clock idles high outside frames
// Notes: Steps of 80 ns keep every change on a falling system clock edge

module oao_i2c_ctrl (
    input wire logic mclk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_drive_n_out
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int QTR = 80;

    initial begin
        scl_out = 1'b1;
        sda_drive_n_out = 1'b1;
    end

    // ************************************************************
    // Bit level
    // ************************************************************
    // Controller alone makes the clock
    task automatic put_bit(input logic b, output logic got);
        sda_drive_n_out = b;
        #QTR scl_out = 1'b1;
        #QTR got = sda_in;
        #QTR scl_out = 1'b0;
        #QTR;
    endtask : put_bit

    task automatic start_cond();
        @(negedge mclk_in);
        sda_drive_n_out = 1'b1;
        scl_out = 1'b1;
        #QTR sda_drive_n_out = 1'b0;
        #QTR scl_out = 1'b0;
        #QTR;
    endtask : start_cond

    task automatic stop_cond();
        sda_drive_n_out = 1'b0;
        #QTR scl_out = 1'b1;
        #QTR sda_drive_n_out = 1'b1;
        // Bus free time also lets a read-cleared alarm reach its pin
        #(3*QTR);
    endtask : stop_cond

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            put_bit(b[i], g);
        end
        put_bit(1'b1, g);
        ack = ~g;
    endtask : send_byte

    task automatic recv_byte(input logic last, output logic [7:0] b);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, b[i]);
        end
        put_bit(last, g);
    endtask : recv_byte

    // ************************************************************
    // Register transfers
    // ************************************************************
    // Caller never passes the alert response address
    task automatic reg_write(input logic [6:0] addr, input logic [7:0] ptr,
                             input int n, input logic [15:0] d,
                             output logic ok);
        logic a;
        start_cond();
        send_byte({addr, 1'b0}, ok);
        if (ok) begin
            send_byte(ptr, a);
            if (n > 0) send_byte(d[15:8], a);
            if (n > 1) send_byte(d[7:0], a);
        end
        stop_cond();
    endtask : reg_write

    task automatic reg_read(input logic [6:0] addr, input logic set_ptr,
                            input logic [7:0] ptr, input int n,
                            output logic [15:0] d, output logic ok);
        logic [7:0] b;
        d = '0;
        if (set_ptr) reg_write(addr, ptr, 0, 16'h0000, ok);
        start_cond();
        send_byte({addr, 1'b1}, ok);
        for (int i = 0; i < n; i++) begin
            recv_byte(i == n - 1, b);
            d = {d[7:0], b};
        end
        stop_cond();
    endtask : reg_read

endmodule : oao_i2c_ctrl

// *** verif/oao_top_tb.sv ***
// Purpose: Self-checking bench for the overtemp alarm block
// Assumes: Conversions are injected by hand as done pulses
// Notes: Alarm pin level is worked out from its pull-up and enable

`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    errors++; $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end

module oao_top_tb;
    import oao_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic [2:0] a_sel = 3'h2;
    logic [TEMP_W-1:0] temp_res = '0;
    logic conv_done = 1'b0;
    logic scl, sda_drive_n, sda_o, sda_oe_n, run, t_valid;
    logic alarm_o, alarm_oe_n, alarm_pin, sda_line, ok;
    logic [1:0] rate;
    logic [15:0] rd_d;
    int errors = 0;
    int samples_checked = 0;

    assign sda_line = sda_drive_n & (sda_oe_n | sda_o);
    assign alarm_pin = alarm_oe_n | alarm_o;
    always #20 mclk = ~mclk;

    oao_top u_oao_top (.mclk_in(mclk), .srst_in(srst), .scl_in(scl),
        .sda_in(sda_line), .sda_out(sda_o), .sda_oe_n_out(sda_oe_n),
        .addr_select_bit2_in(a_sel[2]), .addr_select_bit1_in(a_sel[1]),
        .addr_select_bit0_in(a_sel[0]), .temp_result_in(temp_res),
        .conv_done_in(conv_done), .conv_run_out(run),
        .conv_rate_out(rate), .temp_valid_out(t_valid),
        .overtemp_alarm_out(alarm_o),
        .overtemp_alarm_oe_n_out(alarm_oe_n));
    oao_i2c_ctrl u_oao_i2c_ctrl (.mclk_in(mclk), .sda_in(sda_line),
        .scl_out(scl), .sda_drive_n_out(sda_drive_n));

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [6:0] dev();
        return {ADDR_FIXED, a_sel};
    endfunction : dev

    task automatic conv(input logic [8:0] t9);
        @(negedge mclk);
        temp_res = {t9, 4'h3};
        conv_done = 1'b1;
        @(negedge mclk);
        conv_done = 1'b0;
        repeat (3) @(negedge mclk);
    endtask : conv

    task automatic chk_pin(input logic act, input logic pol);
        `CHK(alarm_pin, pol ? act : ~act)
    endtask : chk_pin

    task automatic wr(input logic [7:0] ptr, input int n,
                      input logic [15:0] d);
        u_oao_i2c_ctrl.reg_write(dev(), ptr, n, d, ok);
        `CHK(ok, 1'b1)
    endtask : wr

    task automatic rd(input logic set_ptr, input logic [7:0] ptr,
                      input int n);
        u_oao_i2c_ctrl.reg_read(dev(), set_ptr, ptr, n, rd_d, ok);
    endtask : rd

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_defaults();
        `CHK(t_valid, 1'b0)
        `CHK(run, 1'b1)
        chk_pin(1'b0, 1'b0);
        conv(9'h083);
        `CHK(t_valid, 1'b1)
        rd(1'b0, PTR_TEMP, 2);
        `CHK(rd_d, {temp_res[12:5], temp_res[4:0], 3'h0})
        rd(1'b1, PTR_CONF, 1);
        `CHK(rd_d[7:0], 8'h00)
        rd(1'b1, PTR_TOS, 2);
        `CHK(rd_d, 16'h5000)
        rd(1'b1, PTR_THYST, 2);
        `CHK(rd_d, 16'h4b00)
    endtask : t_defaults

    task automatic t_comparator();
        conv(9'h0a0);
        chk_pin(1'b0, 1'b0);
        conv(9'h0a1);
        chk_pin(1'b1, 1'b0);
        rd(1'b1, PTR_TEMP, 2);
        chk_pin(1'b1, 1'b0);
        wr(PTR_CONF, 1, 16'h0100);
        `CHK(run, 1'b0)
        chk_pin(1'b1, 1'b0);
        conv(9'h050);
        chk_pin(1'b1, 1'b0);
        rd(1'b1, PTR_CONF, 1);
        `CHK(rd_d[7:0], 8'h01)
        wr(PTR_CONF, 1, 16'h0000);
        `CHK(run, 1'b1)
        conv(9'h096);
        chk_pin(1'b1, 1'b0);
        conv(9'h095);
        chk_pin(1'b0, 1'b0);
    endtask : t_comparator

    task automatic t_queue();
        int need[4] = '{1, 2, 4, 6};
        for (int s = 0; s < 4; s++) begin
            wr(PTR_CONF, 1, {3'h0, s[1:0], 11'h000});
            for (int i = 0; i < need[s] - 1; i++) conv(9'h0b0);
            conv(9'h050);
            for (int i = 0; i < need[s] - 1; i++) conv(9'h0b0);
            chk_pin(1'b0, 1'b0);
            conv(9'h0b0);
            chk_pin(1'b1, 1'b0);
            for (int i = 0; i < need[s] - 1; i++) conv(9'h050);
            chk_pin(1'b1, 1'b0);
            conv(9'h050);
            chk_pin(1'b0, 1'b0);
        end
    endtask : t_queue

    task automatic t_interrupt();
        wr(PTR_CONF, 1, 16'h0200);
        conv(9'h050);
        chk_pin(1'b0, 1'b0);
        conv(9'h0b0);
        chk_pin(1'b1, 1'b0);
        conv(9'h050);
        chk_pin(1'b1, 1'b0);
        rd(1'b0, PTR_CONF, 1);
        chk_pin(1'b0, 1'b0);
        conv(9'h0b0);
        chk_pin(1'b0, 1'b0);
        conv(9'h050);
        chk_pin(1'b1, 1'b0);
        wr(PTR_CONF, 1, 16'h0300);
        chk_pin(1'b0, 1'b0);
        wr(PTR_CONF, 1, 16'h0200);
        conv(9'h050);
        chk_pin(1'b0, 1'b0);
        conv(9'h0b0);
        chk_pin(1'b1, 1'b0);
        rd(1'b1, PTR_TOS, 2);
        chk_pin(1'b0, 1'b0);
    endtask : t_interrupt

    task automatic t_polarity();
        wr(PTR_CONF, 1, 16'h0400);
        chk_pin(1'b0, 1'b1);
        conv(9'h0b0);
        chk_pin(1'b1, 1'b1);
        conv(9'h050);
        chk_pin(1'b0, 1'b1);
    endtask : t_polarity

    // Low limit first so the high limit never sits below it
    task automatic t_limits();
        wr(PTR_CONF, 1, 16'h0000);
        wr(PTR_THYST, 2, 16'hf800);
        wr(PTR_TOS, 2, 16'h0480);
        rd(1'b1, PTR_TOS, 1);
        `CHK(rd_d[7:0], 8'h04)
        rd(1'b0, PTR_TOS, 2);
        `CHK(rd_d, 16'h0480)
        conv(9'h1f8);
        chk_pin(1'b0, 1'b0);
        conv(9'h009);
        chk_pin(1'b0, 1'b0);
        conv(9'h00a);
        chk_pin(1'b1, 1'b0);
        conv(9'h1e0);
        chk_pin(1'b0, 1'b0);
    endtask : t_limits

    task automatic t_address();
        a_sel = 3'h5;
        repeat (4) @(negedge mclk);
        wr(PTR_CONF, 1, 16'h6000);
        `CHK(rate, 2'h3)
        u_oao_i2c_ctrl.reg_write(7'h4c, PTR_CONF, 1, 16'h0000, ok);
        `CHK(ok, 1'b0)
        u_oao_i2c_ctrl.reg_write(7'h45, PTR_CONF, 1, 16'h0000, ok);
        `CHK(ok, 1'b0)
        `CHK(rate, 2'h3)
    endtask : t_address

    // ************************************************************
    // Run control
    // ************************************************************
    task automatic stop_test();
        if (errors == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test

    // Whole run is well under one millisecond of bus traffic
    initial begin
        #2000000;
        errors++;
        stop_test();
    end

    initial begin
        repeat (5) @(negedge mclk);
        srst = 1'b0;
        repeat (3) @(negedge mclk);
        t_defaults();
        t_comparator();
        t_queue();
        t_interrupt();
        t_polarity();
        t_limits();
        t_address();
        stop_test();
    end

endmodule : oao_top_tb
